/* File: rtl/qsg_pkg.sv */
// Shared constants for the questionable status groups block
package qsg_pkg;
  // Register selectors on the command port
  localparam logic [3:0] SEL_CAL_COND      = 4'h0;
  localparam logic [3:0] SEL_CAL_RISE      = 4'h1;
  localparam logic [3:0] SEL_CAL_FALL      = 4'h2;
  localparam logic [3:0] SEL_CAL_EVENT     = 4'h3;
  localparam logic [3:0] SEL_CAL_MASK      = 4'h4;
  localparam logic [3:0] SEL_BIT_ERR_COND  = 4'h5;
  localparam logic [3:0] SEL_BIT_ERR_RISE  = 4'h6;
  localparam logic [3:0] SEL_BIT_ERR_FALL  = 4'h7;
  localparam logic [3:0] SEL_BIT_ERR_EVENT = 4'h8;
  localparam logic [3:0] SEL_BIT_ERR_MASK  = 4'h9;
  // Register width and reset values
  localparam int          REG_W       = 16;
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [15:0] RISE_RESET  = 16'hFFFF;
  // Condition bit positions
  localparam int CAL_FM_ZERO_BIT = 0;
  localparam int CAL_IQ_BIT      = 1;
  localparam int NO_CLOCK_BIT    = 0;
  localparam int NO_DATA_BIT     = 1;
  localparam int SYNC_LOSS_BIT   = 2;
  // Summary bit positions in the parent condition register
  localparam int CAL_SUMMARY_POS     = 8;
  localparam int BIT_ERR_SUMMARY_POS = 12;
  // Timing
  localparam int CLK_HZ           = 100_000_000;
  localparam int NO_CLOCK_TIME_S  = 3;
  localparam int NO_CLOCK_CYCLES  = NO_CLOCK_TIME_S * CLK_HZ;
  localparam int NO_DATA_EDGES    = 200;
endpackage

/* File: rtl/qsg_top.sv */
// Questionable status groups: calibration tail and bit-error-test group
`timescale 1ns/1ps
`default_nettype none
module qsg_top #(
  parameter int NO_CLOCK_LIMIT = qsg_pkg::NO_CLOCK_CYCLES,
  parameter int BIT_ERR_POS    = qsg_pkg::BIT_ERR_SUMMARY_POS
) (
  // Clock and reset
  input  wire  logic        ref_clk_in,
  input  wire  logic        rst_b_in,
  // Command port
  input  wire  logic        cmd_wr_in,
  input  wire  logic        cmd_rd_in,
  input  wire  logic [3:0]  cmd_sel_in,
  input  wire  logic [15:0] cmd_wdata_in,
  input  wire  logic        cmd_reset_in,
  output var   logic [15:0] cmd_rdata_out,
  output var   logic        cmd_rvalid_out,
  // Live status sources
  input  wire  logic        dc_coupled_fm_zero_cal_fail_in,
  input  wire  logic        iq_cal_fail_in,
  input  wire  logic        test_clk_in,
  input  wire  logic        test_data_in,
  input  wire  logic        pseudo_random_pattern_sync_in,
  // Summary bits to the parent register
  output var   logic        cal_summary_out,
  output var   logic        bit_error_test_summary_out,
  output var   logic [15:0] parent_summary_out
);
  localparam int W = qsg_pkg::REG_W;

  // Timing overview for users of this block
  // Calibration condition bits are combinational from the failure inputs,
  // so a calibration change is latched one edge after it appears.
  // The three test condition bits are registered one cycle behind their
  // sources, which keeps the glitchy pin-level status off the latches.
  // An event latch sets one edge after its condition change, and the
  // summary outputs follow one edge after that.
  // A read of an event latch clears it at the read edge; a hit in that
  // same cycle survives the clear, so no transition is ever lost between
  // a host read and the next one.
  // The read answer is registered: read data and the valid pulse come
  // one cycle after the strobe, and the data word holds until the next read.
  // Filters and masks take writes one cycle after the strobe; writes to
  // condition, event or unmapped selectors are dropped on purpose.
  // The rise filters reset to all ones so that every fresh fault is latched
  // without any host set-up; the fall filters reset to zero.
  // The no-clock timeout is a plain cycle count of the system clock.
  // Its limit is a parameter so that short runs can use a small value;
  // the counter is 32 bits, enough for the full multi-second default.
  // The data-activity watch counts test-clock rising edges only, so a
  // stopped test clock freezes it rather than raising the no-data flag.
  // The reset command only holds the sync-loss bit low while it is high;
  // the bit follows the pattern checker again on the next cycle.
  // The test summary position is a parameter because two positions are
  // named for it; only the chosen one is ever driven.

  logic [W-1:0] cal_condition;
  logic [W-1:0] cal_rise_filter;
  logic [W-1:0] cal_fall_filter;
  logic [W-1:0] calibration_event_latch;
  logic [W-1:0] calibration_event_mask;
  logic [W-1:0] bit_error_test_condition;
  logic [W-1:0] bit_error_test_rise_filter;
  logic [W-1:0] bit_error_test_fall_filter;
  logic [W-1:0] bit_error_test_event_latch;
  logic [W-1:0] bit_error_test_event_mask;
  logic [W-1:0] cal_prev;
  logic [W-1:0] bit_err_prev;
  logic [31:0]  no_clock_count;
  logic [7:0]   same_data_count;
  logic         clk_prev;
  logic         data_at_edge;
  logic         no_clock;
  logic         no_data;
  logic         sync_lost;

  // Live condition words; unused positions tied to zero
  assign cal_condition = {14'h0000, iq_cal_fail_in, dc_coupled_fm_zero_cal_fail_in};
  assign bit_error_test_condition = {13'h0000, sync_lost, no_data, no_clock};

  // Selected transitions per bit
  wire [W-1:0] cal_hits = ((~cal_prev & cal_condition) & cal_rise_filter)
                        | ((cal_prev & ~cal_condition) & cal_fall_filter);
  wire [W-1:0] bit_err_hits = ((~bit_err_prev & bit_error_test_condition) & bit_error_test_rise_filter)
                            | ((bit_err_prev & ~bit_error_test_condition) & bit_error_test_fall_filter);

  // Access decode; condition selectors accept no writes
  wire wr_cal_rise  = cmd_wr_in && (cmd_sel_in == qsg_pkg::SEL_CAL_RISE);
  wire wr_cal_fall  = cmd_wr_in && (cmd_sel_in == qsg_pkg::SEL_CAL_FALL);
  wire wr_cal_mask  = cmd_wr_in && (cmd_sel_in == qsg_pkg::SEL_CAL_MASK);
  wire wr_bit_rise  = cmd_wr_in && (cmd_sel_in == qsg_pkg::SEL_BIT_ERR_RISE);
  wire wr_bit_fall  = cmd_wr_in && (cmd_sel_in == qsg_pkg::SEL_BIT_ERR_FALL);
  wire wr_bit_mask  = cmd_wr_in && (cmd_sel_in == qsg_pkg::SEL_BIT_ERR_MASK);
  wire rd_cal_event = cmd_rd_in && (cmd_sel_in == qsg_pkg::SEL_CAL_EVENT);
  wire rd_bit_event = cmd_rd_in && (cmd_sel_in == qsg_pkg::SEL_BIT_ERR_EVENT);

  // Read data; binary word is the weighted sum of set bits
  logic [W-1:0] rd_mux;
  always_comb begin
    unique case (cmd_sel_in)
      qsg_pkg::SEL_CAL_COND:      rd_mux = cal_condition;
      qsg_pkg::SEL_CAL_RISE:      rd_mux = cal_rise_filter;
      qsg_pkg::SEL_CAL_FALL:      rd_mux = cal_fall_filter;
      qsg_pkg::SEL_CAL_EVENT:     rd_mux = calibration_event_latch;
      qsg_pkg::SEL_CAL_MASK:      rd_mux = calibration_event_mask;
      qsg_pkg::SEL_BIT_ERR_COND:  rd_mux = bit_error_test_condition;
      qsg_pkg::SEL_BIT_ERR_RISE:  rd_mux = bit_error_test_rise_filter;
      qsg_pkg::SEL_BIT_ERR_FALL:  rd_mux = bit_error_test_fall_filter;
      qsg_pkg::SEL_BIT_ERR_EVENT: rd_mux = bit_error_test_event_latch;
      qsg_pkg::SEL_BIT_ERR_MASK:  rd_mux = bit_error_test_event_mask;
      default:                    rd_mux = qsg_pkg::REG_RESET;
    endcase
  end

  // Summary terms
  wire cal_sum = |(calibration_event_latch & calibration_event_mask);
  wire bit_sum = |(bit_error_test_event_latch & bit_error_test_event_mask);

  // Sampled test clock edge and data
  wire clk_rise = test_clk_in && !clk_prev;
  wire data_changed = clk_rise && (test_data_in != data_at_edge);

  // Calibration rise filter; all ones so new faults latch by default
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_rise_filter <= qsg_pkg::RISE_RESET;
    end else if (wr_cal_rise) begin
      cal_rise_filter <= cmd_wdata_in;
    end
  end

  // Calibration fall filter
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_fall_filter <= qsg_pkg::REG_RESET;
    end else if (wr_cal_fall) begin
      cal_fall_filter <= cmd_wdata_in;
    end
  end

  // Calibration enable mask
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      calibration_event_mask <= qsg_pkg::REG_RESET;
    end else if (wr_cal_mask) begin
      calibration_event_mask <= cmd_wdata_in;
    end
  end

  // Test rise filter
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_error_test_rise_filter <= qsg_pkg::RISE_RESET;
    end else if (wr_bit_rise) begin
      bit_error_test_rise_filter <= cmd_wdata_in;
    end
  end

  // Test fall filter
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_error_test_fall_filter <= qsg_pkg::REG_RESET;
    end else if (wr_bit_fall) begin
      bit_error_test_fall_filter <= cmd_wdata_in;
    end
  end

  // Test enable mask
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_error_test_event_mask <= qsg_pkg::REG_RESET;
    end else if (wr_bit_mask) begin
      bit_error_test_event_mask <= cmd_wdata_in;
    end
  end

  // Next latch values: new hits win over the read clear
  wire [W-1:0] next_cal_event_latch     = (rd_cal_event ? qsg_pkg::REG_RESET : calibration_event_latch)
                                        | cal_hits;
  wire [W-1:0] next_bit_err_event_latch = (rd_bit_event ? qsg_pkg::REG_RESET : bit_error_test_event_latch)
                                        | bit_err_hits;

  // Calibration event latch
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      calibration_event_latch <= qsg_pkg::REG_RESET;
    end else begin
      calibration_event_latch <= next_cal_event_latch;
    end
  end

  // Test event latch
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_error_test_event_latch <= qsg_pkg::REG_RESET;
    end else begin
      bit_error_test_event_latch <= next_bit_err_event_latch;
    end
  end

  // Previous condition words for edge detection
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_prev     <= qsg_pkg::REG_RESET;
      bit_err_prev <= qsg_pkg::REG_RESET;
    end else begin
      cal_prev     <= cal_condition;
      bit_err_prev <= bit_error_test_condition;
    end
  end

  // No-clock timeout; counter saturates so the flag holds
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_prev       <= 1'b0;
      no_clock_count <= 32'h0000_0000;
      no_clock       <= 1'b0;
    end else begin
      clk_prev <= test_clk_in;
      if (clk_rise) begin
        no_clock_count <= 32'h0000_0000;
        no_clock       <= 1'b0;
      end else if (no_clock_count < 32'(NO_CLOCK_LIMIT)) begin
        no_clock_count <= no_clock_count + 32'h0000_0001;
      end else begin
        no_clock <= 1'b1;
      end
    end
  end

  // Data-activity watch over test clock edges
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_at_edge    <= 1'b0;
      same_data_count <= 8'h00;
      no_data         <= 1'b0;
    end else if (clk_rise) begin
      data_at_edge <= test_data_in;
      if (data_changed) begin
        same_data_count <= 8'h00;
        no_data         <= 1'b0;
      end else if (same_data_count < 8'(qsg_pkg::NO_DATA_EDGES - 1)) begin
        same_data_count <= same_data_count + 8'h01;
      end else begin
        no_data <= 1'b1;
      end
    end
  end

  // Sync loss follows the pattern checker; reset command forces zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_lost <= 1'b0;
    end else if (cmd_reset_in) begin
      sync_lost <= 1'b0;
    end else begin
      sync_lost <= !pseudo_random_pattern_sync_in;
    end
  end

  // Parent word; test position is a parameter because two are named
  wire [W-1:0] next_parent_summary = (16'(cal_sum) << qsg_pkg::CAL_SUMMARY_POS)
                                   | (16'(bit_sum) << BIT_ERR_POS);

  // Read answer; data holds until the next read
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_rdata_out  <= qsg_pkg::REG_RESET;
      cmd_rvalid_out <= 1'b0;
    end else begin
      cmd_rdata_out  <= cmd_rd_in ? rd_mux : cmd_rdata_out;
      cmd_rvalid_out <= cmd_rd_in;
    end
  end

  // Summary outputs, one cycle behind the latches
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_summary_out            <= 1'b0;
      bit_error_test_summary_out <= 1'b0;
      parent_summary_out         <= qsg_pkg::REG_RESET;
    end else begin
      cal_summary_out            <= cal_sum;
      bit_error_test_summary_out <= bit_sum;
      parent_summary_out         <= next_parent_summary;
    end
  end
endmodule
`default_nettype wire

/* File: tb/qsg_asserts.sv */
// Port checker for the questionable status groups block
`timescale 1ns/1ps
`default_nettype none
module qsg_asserts #(
  parameter int BIT_ERR_POS = 12
) (
  // Clock and command port
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic        cmd_rd_in,
  input wire logic        cmd_reset_in,
  input wire logic [3:0]  cmd_sel_in,
  input wire logic [15:0] cmd_rdata_out,
  input wire logic        cmd_rvalid_out,
  // Status sources and summaries
  input wire logic        dc_coupled_fm_zero_cal_fail_in,
  input wire logic        iq_cal_fail_in,
  input wire logic        pseudo_random_pattern_sync_in,
  input wire logic        cal_summary_out,
  input wire logic        bit_error_test_summary_out,
  input wire logic [15:0] parent_summary_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Read request for one selector
  sequence s_rd(logic [3:0] s);
    cmd_rd_in && cmd_sel_in == s;
  endsequence
  a_rvalid_after_read: assert property (cmd_rd_in |=> cmd_rvalid_out) else $error("no read answer");
  a_rvalid_only_read: assert property (cmd_rvalid_out |-> $past(cmd_rd_in)) else $error("stray read answer");
  a_parent_cal_bit: assert property (parent_summary_out[8] == cal_summary_out) else $error("cal summary bit");
  a_parent_test_bit: assert property (parent_summary_out[BIT_ERR_POS] == bit_error_test_summary_out)
    else $error("test summary bit");
  a_parent_others_zero: assert property ((parent_summary_out & ~(16'h0100 | (16'h0001 << BIT_ERR_POS))) == 16'h0000)
    else $error("parent spare bit set");
  a_cal_cond_live: assert property (s_rd(qsg_pkg::SEL_CAL_COND) |=> cmd_rdata_out ==
    {14'h0, $past(iq_cal_fail_in), $past(dc_coupled_fm_zero_cal_fail_in)}) else $error("cal condition");
  a_cond_unused_zero: assert property (s_rd(qsg_pkg::SEL_BIT_ERR_COND) |=> cmd_rdata_out[15:3] == 13'h0)
    else $error("unused condition bit");
  a_sync_cond_bit: assert property (s_rd(qsg_pkg::SEL_BIT_ERR_COND) |=>
    cmd_rdata_out[2] == (!$past(pseudo_random_pattern_sync_in, 2) && !$past(cmd_reset_in, 2)))
    else $error("sync loss bit");
  a_unmapped_zero: assert property (s_rd(4'hA) |=> cmd_rdata_out == 16'h0000) else $error("unmapped read");
endmodule
bind qsg_top qsg_asserts #(.BIT_ERR_POS(BIT_ERR_POS)) qsg_asserts_i (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
  .cmd_rd_in(cmd_rd_in), .cmd_reset_in(cmd_reset_in), .cmd_sel_in(cmd_sel_in), .cmd_rdata_out(cmd_rdata_out),
  .cmd_rvalid_out(cmd_rvalid_out),
  .dc_coupled_fm_zero_cal_fail_in(dc_coupled_fm_zero_cal_fail_in), .iq_cal_fail_in(iq_cal_fail_in),
  .pseudo_random_pattern_sync_in(pseudo_random_pattern_sync_in), .cal_summary_out(cal_summary_out),
  .bit_error_test_summary_out(bit_error_test_summary_out), .parent_summary_out(parent_summary_out));
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the questionable status groups block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        ref_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        wr = 1'b0;
  logic        rd_s = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rdat;
  logic        rv;
  logic        fm = 1'b0;
  logic        iq = 1'b0;
  logic        tck = 1'b0;
  logic        tdat = 1'b0;
  logic        sync = 1'b1;
  logic        rst_cmd = 1'b0;
  logic        cal_s;
  logic        tst_s;
  logic [15:0] par;
  logic [15:0] v;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  // Short no-clock limit keeps the run brief
  qsg_top #(.NO_CLOCK_LIMIT(50), .BIT_ERR_POS(12)) qsg_top_i (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .cmd_wr_in(wr), .cmd_rd_in(rd_s), .cmd_sel_in(sel), .cmd_wdata_in(wd), .cmd_reset_in(rst_cmd),
    .cmd_rdata_out(rdat), .cmd_rvalid_out(rv), .dc_coupled_fm_zero_cal_fail_in(fm), .iq_cal_fail_in(iq),
    .test_clk_in(tck), .test_data_in(tdat), .pseudo_random_pattern_sync_in(sync), .cal_summary_out(cal_s),
    .bit_error_test_summary_out(tst_s), .parent_summary_out(par));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Command cycles: one-cycle strobes launched just after the edge
  task automatic wrc(input logic [3:0] s, input logic [15:0] d);
    @(posedge ref_clk_in);
    #1;
    wr = 1'b1;
    sel = s;
    wd = d;
    @(posedge ref_clk_in);
    #1;
    wr = 1'b0;
  endtask
  task automatic rc(input logic [3:0] s, input logic [15:0] e, input logic [15:0] m);
    @(posedge ref_clk_in);
    #1;
    rd_s = 1'b1;
    sel = s;
    @(posedge ref_clk_in);
    #1;
    rd_s = 1'b0;
    check({15'h0, rv}, 16'h0001);
    check(rdat & m, e);
  endtask
  // Each of the n iterations toggles the test clock once, two core cycles apart
  task automatic pulse(input int n, input logic tog);
    repeat (n) begin
      @(posedge ref_clk_in);
      #1;
      tck = ~tck;
      tdat = tdat ^ (tog & ~tck);
      @(posedge ref_clk_in);
    end
  endtask
  task automatic t_reset_vals();
    logic [15:0] exp_t [10] = '{16'h0, 16'hFFFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'hFFFF, 16'h0, 16'h0, 16'h0};
    for (int i = 0; i < 10; i++) rc(4'(i), exp_t[i], 16'hFFFF);
  endtask
  task automatic t_masks();
    wrc(4'h4, 16'h0003);
    wrc(4'h9, 16'h0006);
    wrc(4'h5, 16'hFFFF);
    wrc(4'hA, 16'hFFFF);
    rc(4'h4, 16'h0003, 16'hFFFF);
    rc(4'h9, 16'h0006, 16'hFFFF);
    rc(4'h5, 16'h0000, 16'hFFF8);
    rc(4'hA, 16'h0000, 16'hFFFF);
    wrc(4'h9, 16'h0004);
  endtask
  task automatic t_cal();
    fm = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    #1;
    check(par, 16'h0100);
    check({15'h0, cal_s}, 16'h0001);
    rc(4'h3, 16'h0001, 16'hFFFF);
    rc(4'h3, 16'h0000, 16'hFFFF);
    check({15'h0, cal_s}, 16'h0000);
    fm = 1'b0;
    rc(4'h3, 16'h0000, 16'hFFFF);
  endtask
  task automatic t_sync();
    rc(4'h8, 16'h0000, 16'h0000);
    sync = 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    check(par, 16'h1000);
    check({15'h0, tst_s}, 16'h0001);
    rc(4'h5, 16'h0004, 16'h0004);
    rst_cmd = 1'b1;
    rc(4'h5, 16'h0000, 16'h0004);
    rst_cmd = 1'b0;
    wrc(4'h6, 16'h0000);
    wrc(4'h7, 16'h0004);
    rc(4'h8, 16'h0004, 16'h0004);
    sync = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    rc(4'h8, 16'h0004, 16'h0004);
    @(posedge ref_clk_in);
    #1;
    check({15'h0, tst_s}, 16'h0000);
  endtask
  task automatic t_clock();
    pulse(410, 1'b0);
    rc(4'h5, 16'h0002, 16'h0003);
    pulse(6, 1'b1);
    rc(4'h5, 16'h0000, 16'h0003);
    repeat (60) @(posedge ref_clk_in);
    rc(4'h5, 16'h0001, 16'h0003);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the roughly one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (4) @(posedge ref_clk_in);
    #1;
    rst_b_in = 1'b1;
    t_reset_vals();
    t_masks();
    t_cal();
    t_sync();
    t_clock();
    results();
  end
endmodule
`default_nettype wire
